// [design/ossc_spi_ctrl.sv]
// Octal switch serial control: shift register, output latch, fault filter
`timescale 1ns/100ps
`default_nettype none
`include "ossc_regs.svh"

module ossc_spi_ctrl #(
   parameter int FAULT_CYCLES = `OSSC_FAULT_CYCLES,
   parameter int CNT_W = `OSSC_FAULT_CNT_W
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire ossc_pkg::ossc_pins_type pinsIn,
   input wire ossc_pkg::ossc_fault_type faultIn,
   output logic [`OSSC_CHANNELS-1:0] drainOutputs,
   output logic chargePumpOn,
   output logic serialOut,
   output logic serialOutEn
);
   import ossc_pkg::*;

   localparam int N = `OSSC_CHANNELS;

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   ossc_pins_type pinsSync;
   ossc_pins_type pinsPrev_q;
   ossc_fault_type faultSync;

   ossc_pin_sync #(
      .WIDTH($bits(ossc_pins_type)),
      .RST_VAL(`OSSC_PINS_RST)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(pinsIn),
      .syncOut(pinsSync)
   );

   // Fault detectors live in the analog domain, so they are synchronised too
   ossc_pin_sync #(
      .WIDTH($bits(ossc_fault_type)),
      .RST_VAL(`OSSC_FAULT_RST)
   ) u_fault_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .asyncIn(faultIn),
      .syncOut(faultSync)
   );

   // Previous filtered levels for edge finding
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinsPrev_q <= `OSSC_PINS_RST;
      end else begin
         pinsPrev_q <= pinsSync;
      end
   end

   // ------------------------------------------------------------
   // Edge decode
   // ------------------------------------------------------------
   wire logic csFall;
   wire logic csRise;
   wire logic sclkFall;
   wire logic sclkRise;
   wire logic enF;
   assign csFall = pinsPrev_q.chipSelectN & ~pinsSync.chipSelectN;
   assign csRise = ~pinsPrev_q.chipSelectN & pinsSync.chipSelectN;
   assign sclkFall = pinsPrev_q.serialClk & ~pinsSync.serialClk;
   assign sclkRise = ~pinsPrev_q.serialClk & pinsSync.serialClk;
   assign enF = pinsSync.enableIn;

   // ------------------------------------------------------------
   // Fault filter
   // ------------------------------------------------------------
   wire logic [N-1:0] faultRaw;
   logic [N-1:0] faultStatus;
   assign faultRaw = faultSync.openLoad | faultSync.shortLoad;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_filter
         logic [CNT_W-1:0] count_q;
         logic [CNT_W-1:0] count_d;
         wire logic full;
         assign full = (count_q == CNT_W'(FAULT_CYCLES));
         // Detection suspended without enable; short glitches never report
         assign count_d = (!enF || !faultRaw[i]) ? '0 :
                          full ? count_q : count_q + 1'b1;
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               count_q <= '0;
            end else begin
               count_q <= count_d;
            end
         end
         assign faultStatus[i] = full;
      end
   endgenerate

   // ------------------------------------------------------------
   // Link state machine
   // ------------------------------------------------------------
   ossc_link_state_type state_q;
   ossc_link_state_type state_d;
   wire logic selected;
   assign selected = (state_q == OSSC_SELECTED);

   // Select edges decide the frame; clock edges only matter inside it
   always_comb begin
      state_d = state_q;
      case (state_q)
         OSSC_IDLE: begin
            if (csFall) begin
               state_d = OSSC_SELECTED;
            end
         end
         OSSC_SELECTED: begin
            if (csRise) begin
               state_d = OSSC_IDLE;
            end
         end
         default: begin
            state_d = OSSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= OSSC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Shift register
   // ------------------------------------------------------------
   logic [N-1:0] shift_q;
   logic [N-1:0] shift_d;
   wire logic doShift;
   assign doShift = selected && !csRise && sclkFall;

   // Fault capture on select fall; data enters at the LSB, leaves at the MSB
   assign shift_d = (!selected && csFall) ? faultStatus :
                    doShift ? {shift_q[N-2:0], pinsSync.serialIn} :
                    shift_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shift_q <= `OSSC_SHIFT_RST;
      end else begin
         shift_q <= shift_d;
      end
   end

   // ------------------------------------------------------------
   // Output latch and drivers
   // ------------------------------------------------------------
   logic [N-1:0] latch_q;
   wire logic [N-1:0] pwmMask;
   wire logic [N-1:0] driveCmd;

   // Latch only at select release, so partial frames never reach the loads
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         latch_q <= `OSSC_LATCH_RST;
      end else if (selected && csRise) begin
         latch_q <= shift_q;
      end
   end

   assign pwmMask = ({{(N-1){1'b0}}, pinsSync.pwmInputFive} << `OSSC_PWM_FIVE_BIT) |
                    ({{(N-1){1'b0}}, pinsSync.pwmInputSix} << `OSSC_PWM_SIX_BIT);
   // Latch is kept while disabled, so outputs come back without a new command
   assign driveCmd = enF ? (latch_q | pwmMask) : '0;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         drainOutputs <= '0;
         chargePumpOn <= 1'b0;
      end else begin
         drainOutputs <= driveCmd;
         chargePumpOn <= enF;
      end
   end

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   // Low until the first rising clock puts the MSB out
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end else if (!selected) begin
         serialOut <= 1'b0;
         serialOutEn <= csFall;
      end else if (csRise) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end else if (sclkRise) begin
         serialOut <= shift_q[`OSSC_MSB_BIT];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_idle_ignores;
      @(posedge ref_clk) disable iff (sys_rst)
      (!selected && !csFall) |=> ($stable(shift_q) && !serialOutEn);
   endproperty
   a_idle_ignores: assert property (p_idle_ignores)
      else $error("shift or driver changed while deselected");

   property p_release_latch;
      @(posedge ref_clk) disable iff (sys_rst)
      (selected && csRise) |=> (latch_q == $past(shift_q)) ##1
         (!$past(enF) || ((drainOutputs & ~$past(pwmMask)) == (latch_q & ~$past(pwmMask))));
   endproperty
   a_release_latch: assert property (p_release_latch)
      else $error("select release did not move shift word to outputs");

   property p_fault_capture;
      @(posedge ref_clk) disable iff (sys_rst)
      (!selected && csFall) |=> (shift_q == $past(faultStatus)) && serialOutEn;
   endproperty
   a_fault_capture: assert property (p_fault_capture)
      else $error("status not captured at select fall");

   property p_driver_on;
      @(posedge ref_clk) disable iff (sys_rst)
      (!selected && csFall) |=> serialOutEn [*2];
   endproperty
   a_driver_on: assert property (p_driver_on)
      else $error("serial output driver not enabled");

   property p_shift_in;
      @(posedge ref_clk) disable iff (sys_rst)
      doShift |=> shift_q == {$past(shift_q[N-2:0]), $past(pinsSync.serialIn)};
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("falling clock did not shift data in");

   property p_msb_out;
      @(posedge ref_clk) disable iff (sys_rst)
      (selected && !csRise && sclkRise) |=> serialOut == $past(shift_q[`OSSC_MSB_BIT]);
   endproperty
   a_msb_out: assert property (p_msb_out)
      else $error("rising clock did not present next bit");

   property p_disable_off;
      @(posedge ref_clk) disable iff (sys_rst)
      !enF |=> (drainOutputs == '0) && !chargePumpOn && (faultStatus == '0);
   endproperty
   a_disable_off: assert property (p_disable_off)
      else $error("outputs or faults active while disabled");

   property p_resume;
      @(posedge ref_clk) disable iff (sys_rst)
      (enF && $stable(latch_q)) |=>
         ((drainOutputs & ~$past(pwmMask)) == ($past(latch_q) & ~$past(pwmMask)));
   endproperty
   a_resume: assert property (p_resume)
      else $error("latched outputs not driven with enable high");

   property p_pwm_or;
      @(posedge ref_clk) disable iff (sys_rst)
      (enF && pinsSync.pwmInputFive && pinsSync.pwmInputSix)
         |=> drainOutputs[`OSSC_PWM_SIX_BIT:`OSSC_PWM_FIVE_BIT] == 2'h3;
   endproperty
   a_pwm_or: assert property (p_pwm_or)
      else $error("direct input not ORed into output");

   property p_reset_off;
      @(posedge ref_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (drainOutputs == '0) && !serialOutEn && (latch_q == '0);
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("drivers not off after reset");

   property p_filter;
      @(posedge ref_clk) disable iff (sys_rst)
      (!faultRaw[0] || !enF) |=> !faultStatus[0] [*2];
   endproperty
   a_filter: assert property (p_filter)
      else $error("fault reported without persisting");

   property p_hold_latch;
      @(posedge ref_clk) disable iff (sys_rst)
      !(selected && csRise) |=> $stable(latch_q);
   endproperty
   a_hold_latch: assert property (p_hold_latch)
      else $error("latched state changed outside select release");

   // Main scenarios
   property p_cov_frame;
      @(posedge ref_clk) disable iff (sys_rst)
      (!selected && csFall) ##[1:1000] (selected && csRise);
   endproperty
   c_cov_frame: cover property (p_cov_frame);

   property p_cov_fault;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(faultStatus[0]);
   endproperty
   c_cov_fault: cover property (p_cov_fault);

   property p_cov_resume;
      @(posedge ref_clk) disable iff (sys_rst)
      $rose(enF) && (latch_q != '0);
   endproperty
   c_cov_resume: cover property (p_cov_resume);

   property p_cov_pwm;
      @(posedge ref_clk) disable iff (sys_rst)
      enF && pinsSync.pwmInputFive && !latch_q[`OSSC_PWM_FIVE_BIT];
   endproperty
   c_cov_pwm: cover property (p_cov_pwm);

endmodule : ossc_spi_ctrl

`default_nettype wire

// [design/ossc_regs.svh]
// Constants of the octal switch serial control block
`ifndef OSSC_REGS_SVH
`define OSSC_REGS_SVH

// ------------------------------------------------------------
// Word layout
// ------------------------------------------------------------
`define OSSC_CHANNELS 8
`define OSSC_MSB_BIT 7
`define OSSC_PWM_FIVE_BIT 4
`define OSSC_PWM_SIX_BIT 5

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define OSSC_SHIFT_RST 8'h00
`define OSSC_LATCH_RST 8'h00
`define OSSC_PINS_RST 6'h20
`define OSSC_FAULT_RST 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OSSC_CLK_MHZ 100
`define OSSC_FAULT_TIME_US 300
`define OSSC_FAULT_CYCLES (`OSSC_FAULT_TIME_US * `OSSC_CLK_MHZ)
`define OSSC_FAULT_CNT_W 16

`endif

// [design/ossc_pkg.sv]
// Types shared by the octal switch serial control block
`include "ossc_regs.svh"

package ossc_pkg;

   // Pins from the host side, all outside the clock domain
   typedef struct packed {
      logic chipSelectN;
      logic serialClk;
      logic serialIn;
      logic enableIn;
      logic pwmInputFive;
      logic pwmInputSix;
   } ossc_pins_type;

   // Raw per-output fault detector levels from the power stage
   typedef struct packed {
      logic [`OSSC_CHANNELS-1:0] openLoad;
      logic [`OSSC_CHANNELS-1:0] shortLoad;
   } ossc_fault_type;

   typedef enum logic [0:0] {
      OSSC_IDLE = 1'b0,
      OSSC_SELECTED = 1'b1
   } ossc_link_state_type;

endpackage : ossc_pkg

// [design/ossc_pin_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module ossc_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // ------------------------------------------------------------
   // Per-bit chain
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic stage1_q;
         logic stage2_q;
         logic stage3_q;
         logic out_q;
         // Stage one feeds stage two only; output moves when two and three agree
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               stage1_q <= RST_VAL[i];
               stage2_q <= RST_VAL[i];
               stage3_q <= RST_VAL[i];
               out_q <= RST_VAL[i];
            end else begin
               stage1_q <= asyncIn[i];
               stage2_q <= stage1_q;
               stage3_q <= stage2_q;
               if (stage2_q == stage3_q) begin
                  out_q <= stage3_q;
               end
            end
         end
         assign syncOut[i] = out_q;
      end
   endgenerate

endmodule : ossc_pin_sync

`default_nettype wire

// [dv/ossc_host_model.sv]
// Host-side serial master model driving the octal switch link pins
`timescale 1ns/100ps
`default_nettype none

module ossc_host_model (
   input wire logic ref_clk,
   input wire logic serialOut,
   input wire logic serialOutEn,
   output logic chipSelectN,
   output logic serialClk,
   output logic serialIn
);
   int enSeen;

   // Idle: deselected, clock parked low
   initial begin
      chipSelectN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
      enSeen = 0;
   end

   // One half period of the 160 ns link clock; leaves just after an edge
   task automatic half();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : half

   // Frame of n bits, first bit sent is the top one; status comes back
   task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      enSeen = 1;
      chipSelectN = 1'b0; // Clock is low at this edge
      half();
      for (int i = n - 1; i >= 0; i--) begin
         serialIn = tx[i]; // Changed at the rising clock, far from sampling
         serialClk = 1'b1;
         half();
         rx = {rx[14:0], serialOutEn ? serialOut : 1'bx};
         if (serialOutEn !== 1'b1) enSeen = 0;
         serialClk = 1'b0;
         half();
      end
      chipSelectN = 1'b1; // Clock low again at release
      serialIn = ~serialIn; // Released line must not keep the last value
      half();
   endtask : frame

   // Clock and data activity while deselected, which must be ignored
   task automatic noise();
      for (int i = 0; i < 4; i++) begin
         serialClk = 1'b1;
         serialIn = ~serialIn;
         half();
         serialClk = 1'b0;
         half();
      end
   endtask : noise
endmodule : ossc_host_model

`default_nettype wire

// [dv/octal_switch_spi_control_bench.sv]
// Self-checking bench for the octal switch serial control block
`timescale 1ns/100ps
`default_nettype none

module octal_switch_spi_control_bench;
   import ossc_pkg::*;
   logic ref_clk, sys_rst, enableIn, pwmFive, pwmSix;
   logic csN, sclk, sdi, chargePumpOn, serialOut, serialOutEn;
   logic [7:0] drainOutputs;
   logic [15:0] rx;
   ossc_fault_type faultIn;
   ossc_pins_type pinsIn;
   int mismatches, total_checks;

   // Pin bundle: link pins from the host model, the rest from the bench
   assign pinsIn = '{chipSelectN: csN, serialClk: sclk, serialIn: sdi,
                     enableIn: enableIn, pwmInputFive: pwmFive, pwmInputSix: pwmSix};

   ossc_spi_ctrl #(.FAULT_CYCLES(20), .CNT_W(16)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .pinsIn(pinsIn), .faultIn(faultIn),
      .drainOutputs(drainOutputs), .chargePumpOn(chargePumpOn),
      .serialOut(serialOut), .serialOutEn(serialOutEn));

   ossc_host_model host (
      .ref_clk(ref_clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
      .chipSelectN(csN), .serialClk(sclk), .serialIn(sdi));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Pin-to-port latency is a handful of cycles; twelve covers it
   task automatic settle();
      repeat (12) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic send(input int n, input logic [15:0] tx);
      host.frame(n, tx, rx);
      settle();
   endtask : send

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk("drain in reset", {8'h00, drainOutputs}, 16'h0000);
      chk("pump in reset", {15'h0, chargePumpOn}, 16'h0000);
      chk("out enable in reset", {15'h0, serialOutEn}, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_write();
      send(8, 16'h00A5);
      chk("drain after frame", {8'h00, drainOutputs}, 16'h00A5);
      chk("status no faults", rx, 16'h0000);
      chk("out enabled in frame", host.enSeen[15:0], 16'h0001);
      chk("out released", {15'h0, serialOutEn}, 16'h0000);
      host.noise();
      chk("drain after noise", {8'h00, drainOutputs}, 16'h00A5);
      chk("out still released", {15'h0, serialOutEn}, 16'h0000);
      send(8, 16'h005A);
      chk("drain second word", {8'h00, drainOutputs}, 16'h005A);
      $display("test write done");
   endtask : t_write

   task automatic t_status();
      faultIn = '{openLoad: 8'h81, shortLoad: 8'h24};
      send(8, 16'h005A);
      chk("status before filter", rx, 16'h0000);
      send(8, 16'h005A);
      chk("status word", rx, 16'h00A5);
      send(16, 16'hC35A);
      chk("chained return", rx, 16'hA5C3);
      chk("chained word", {8'h00, drainOutputs}, 16'h005A);
      faultIn = '{openLoad: 8'h00, shortLoad: 8'h00};
      $display("test status done");
   endtask : t_status

   task automatic t_enable();
      faultIn = '{openLoad: 8'hFF, shortLoad: 8'h00};
      enableIn = 1'b0;
      settle();
      chk("drain enable low", {8'h00, drainOutputs}, 16'h0000);
      chk("pump enable low", {15'h0, chargePumpOn}, 16'h0000);
      // Resume is checked before any new frame, so only the kept latch can restore it
      enableIn = 1'b1;
      settle();
      chk("drain resumed", {8'h00, drainOutputs}, 16'h005A);
      chk("pump resumed", {15'h0, chargePumpOn}, 16'h0001);
      enableIn = 1'b0;
      repeat (40) @(posedge ref_clk);
      #1;
      send(8, 16'h005A);
      chk("status enable low", rx, 16'h0000);
      enableIn = 1'b1;
      settle();
      faultIn = '{openLoad: 8'h00, shortLoad: 8'h00};
      $display("test enable done");
   endtask : t_enable

   task automatic t_pwm();
      send(8, 16'h0000); // Serial bits five and six off for direct use
      pwmFive = 1'b1;
      settle();
      chk("pwm five", {8'h00, drainOutputs}, 16'h0010);
      pwmSix = 1'b1;
      settle();
      chk("pwm both", {8'h00, drainOutputs}, 16'h0030);
      repeat (25000) @(posedge ref_clk); // Half of a 2 kHz period
      #1;
      pwmFive = 1'b0;
      pwmSix = 1'b0;
      settle();
      chk("pwm off", {8'h00, drainOutputs}, 16'h0000);
      $display("test pwm done");
   endtask : t_pwm

   // ------------------------------------------------------------
   // Clock, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Main sequence; inputs change one step after the rising edge
   initial begin
      mismatches = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      enableIn = 1'b1;
      pwmFive = 1'b0;
      pwmSix = 1'b0;
      faultIn = '{openLoad: 8'h00, shortLoad: 8'h00};
      repeat (3) @(posedge ref_clk);
      #1;
      t_reset();
      sys_rst = 1'b0;
      settle();
      t_write();
      t_status();
      t_enable();
      t_pwm();
      close_out();
   end

   // Whole run needs about 26400 cycles; a hang is cut off well past that
   initial begin
      repeat (60000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
endmodule : octal_switch_spi_control_bench

`default_nettype wire
